// ---- fic_defs.vh ----
// constants of the fusion configuration register bank
// What the document requires of this block and its host
// R1: compass rate value is rate in hertz
// R2: accel rate value is rate over ten
// R3: gyro rate value is rate over ten
// R4: zero rate shuts sensor and calibration down
// R5: unsupported rate rounds up to next supported; code rounds accel and gyro only, compass rate passes through unrounded
// R6: orientation rate is gyro rate over divisor
// R7: divisor resets zero, zero acts as one
// R8: control bit 0 allows standby
// R9: control bit 1 selects raw sensor data
// R10: control bit 2 selects euler, fourth zero
// R11: control bit 3 selects 6dof fusion
// R12: control bit 5 selects enu axes
// R13: control bit 6 lets gyro sleep when still
// R14: control register resets to zero
// R15: host sets 6dof when no compass
// R16: enable bits gate each event interrupt
// R17: core restart event always interrupts
// R18: multi byte write advances register address
// R19: host should enable error interrupt
// R20: status flags undefined while a rate zero
// R21: host sets all rates nonzero first
// R22: registers hold until written or reset
`ifndef FIC_DEFS_VH
`define FIC_DEFS_VH
`define FIC_IDX_QDIV 7'h32
`define FIC_IDX_EVEN 7'h33
`define FIC_IDX_ALGO 7'h54
`define FIC_IDX_MAG 7'h55
`define FIC_IDX_ACC 7'h56
`define FIC_IDX_GYR 7'h57
`define FIC_IDX_STAT 7'h58
`define FIC_RST_QDIV 8'h00
`define FIC_RST_EVEN 8'h01
`define FIC_RST_ALGO 8'h00
`define FIC_RST_RATE 8'h00
`define FIC_ALGO_STANDBY 0
`define FIC_ALGO_RAW 1
`define FIC_ALGO_EULER 2
`define FIC_ALGO_6DOF 3
`define FIC_ALGO_ENU 5
`define FIC_ALGO_GYRO_OFF 6
`define FIC_ALGO_MASK 8'h6f
`define FIC_EVEN_MASK 8'h3f
`define FIC_EV_RESTART 0
`define FIC_EV_ERROR 1
`define FIC_EV_ORIENT 2
`define FIC_EV_COMPASS 3
`define FIC_EV_ACCEL 4
`define FIC_EV_ROTATION 5
`define FIC_RATE_SCALE 12'd10
`define FIC_RATE_W 12
`endif

// ---- fic_odr.v ----
// picks the sensor output rate actually used for a requested rate
`include "fic_defs.vh"
module fic_odr #(
  parameter N = 8,
  parameter [N*`FIC_RATE_W-1:0] RATES = {12'd1600, 12'd800, 12'd400, 12'd200,
                                         12'd100, 12'd50, 12'd25, 12'd10}
) (
  input wire [`FIC_RATE_W-1:0] req_hz,
  output reg [`FIC_RATE_W-1:0] use_hz,
  output wire on
);
  // table is ascending; first entry at or above the request wins
  wire [N-1:0] fits;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_fit
      assign fits[g] = RATES[g*`FIC_RATE_W +: `FIC_RATE_W] >= req_hz;
    end
  endgenerate

  integer i;
  reg hit;
  always @* begin
    hit = 1'b0;
    // a request above the table saturates at the fastest rate
    use_hz = RATES[(N-1)*`FIC_RATE_W +: `FIC_RATE_W];
    for (i = 0; i < N; i = i + 1) begin
      if (fits[i] && !hit) begin
        use_hz = RATES[i*`FIC_RATE_W +: `FIC_RATE_W]; // see R5
        hit = 1'b1;
      end
    end
    if (req_hz == {`FIC_RATE_W{1'b0}}) begin
      use_hz = {`FIC_RATE_W{1'b0}}; // see R4
    end
  end

  assign on = req_hz != {`FIC_RATE_W{1'b0}}; // see R4
endmodule // fic_odr

// ---- fic_regs.v ----
// configuration register bank of the fusion coprocessor, apb slave
//
// Added by the designer: the APB interface to the registers.
`include "fic_defs.vh"
module fic_regs #(
  parameter ACC_N = 8,
  parameter [ACC_N*`FIC_RATE_W-1:0] ACC_RATES = {12'd1600, 12'd800, 12'd400, 12'd200,
                                                 12'd100, 12'd50, 12'd25, 12'd10},
  parameter GYR_N = 8,
  parameter [GYR_N*`FIC_RATE_W-1:0] GYR_RATES = {12'd1600, 12'd800, 12'd400, 12'd200,
                                                 12'd100, 12'd50, 12'd25, 12'd10}
) (
  input wire core_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [5:0] event_pulse,
  input wire rotation_sample,
  input wire [2:0] flags_in,
  output reg host_irq,
  output reg orientation_tick,
  output reg [`FIC_RATE_W-1:0] compass_rate_hz,
  output reg [`FIC_RATE_W-1:0] accel_rate_hz,
  output reg [`FIC_RATE_W-1:0] rotation_rate_hz,
  output reg [2:0] sensor_on,
  output reg [2:0] calib_on,
  output reg standby_allow,
  output reg unscaled_output_select,
  output reg euler_output_select,
  output reg six_dof_select,
  output reg enu_axes_select,
  output reg gyro_still_off_allow,
  output reg [2:0] flags_out,
  output reg flags_valid
);
  reg [7:0] orientation_rate_divisor_q;
  reg [7:0] event_interrupt_enable_q;
  reg [7:0] fusion_option_control_q;
  reg [7:0] compass_rate_q;
  reg [7:0] accel_rate_div10_q;
  reg [7:0] rotation_rate_div10_q;
  reg [7:0] div_cnt_q;
  reg [7:0] status_d;
  reg [7:0] rd_byte;
  reg [31:0] rd_d;
  reg err_d;

  // byte address is four times the register index
  wire [6:0] idx = paddr[8:2];
  wire addr_ok = paddr[31:9] == 23'h000000 && paddr[1:0] == 2'b00;
  wire setup = psel && !penable;
  wire commit = psel && penable && pready;
  wire do_wr = commit && pwrite && !pslverr;

  function is_cfg;
    input [6:0] i;
    begin
      is_cfg = i == `FIC_IDX_QDIV || i == `FIC_IDX_EVEN ||
               (i >= `FIC_IDX_ALGO && i <= `FIC_IDX_GYR);
    end
  endfunction

  // lane k of a write lands on index + k, so one word fills
  // consecutive rate registers from a single transfer
  wire [6:0] lane_idx0 = idx;
  wire [6:0] lane_idx1 = idx + 7'd1;
  wire [6:0] lane_idx2 = idx + 7'd2;
  wire [6:0] lane_idx3 = idx + 7'd3;

  function [7:0] lane_pick;
    input [6:0] target;
    input [7:0] cur;
    input [6:0] i0;
    input [6:0] i1;
    input [6:0] i2;
    input [6:0] i3;
    input [3:0] strb;
    input [31:0] data;
    begin
      lane_pick = cur;
      if (strb[0] && i0 == target) begin
        lane_pick = data[7:0];
      end
      if (strb[1] && i1 == target) begin
        lane_pick = data[15:8];
      end
      if (strb[2] && i2 == target) begin
        lane_pick = data[23:16];
      end
      if (strb[3] && i3 == target) begin
        lane_pick = data[31:24];
      end
    end
  endfunction

  // rate values scaled to hertz
  wire [`FIC_RATE_W-1:0] mag_req_hz = {4'h0, compass_rate_q}; // see R1
  wire [`FIC_RATE_W-1:0] acc_req_hz;
  wire [`FIC_RATE_W-1:0] gyr_req_hz;
  wire [23:0] acc_prod = {16'h0000, accel_rate_div10_q} * {12'h000, `FIC_RATE_SCALE};
  wire [23:0] gyr_prod = {16'h0000, rotation_rate_div10_q} * {12'h000, `FIC_RATE_SCALE};
  assign acc_req_hz = acc_prod[`FIC_RATE_W-1:0]; // see R2
  assign gyr_req_hz = gyr_prod[`FIC_RATE_W-1:0]; // see R3

  wire [`FIC_RATE_W-1:0] acc_use_hz;
  wire [`FIC_RATE_W-1:0] gyr_use_hz;
  wire acc_on;
  wire gyr_on;

  fic_odr #(
    .N(ACC_N),
    .RATES(ACC_RATES)
  ) u_acc_odr (
    .req_hz(acc_req_hz),
    .use_hz(acc_use_hz),
    .on(acc_on)
  );

  fic_odr #(
    .N(GYR_N),
    .RATES(GYR_RATES)
  ) u_gyr_odr (
    .req_hz(gyr_req_hz),
    .use_hz(gyr_use_hz),
    .on(gyr_on)
  );

  wire mag_on = compass_rate_q != 8'h00; // see R4
  wire all_on = mag_on && acc_on && gyr_on;

  always @* begin
    status_d = {4'h0, gyr_on, acc_on, mag_on, all_on};
  end

  // read data is latched in the setup cycle so prdata is a flop
  always @* begin
    rd_byte = 8'h00;
    case (idx)
      `FIC_IDX_QDIV: rd_byte = orientation_rate_divisor_q;
      `FIC_IDX_EVEN: rd_byte = event_interrupt_enable_q;
      `FIC_IDX_ALGO: rd_byte = fusion_option_control_q;
      `FIC_IDX_MAG: rd_byte = compass_rate_q;
      `FIC_IDX_ACC: rd_byte = accel_rate_div10_q;
      `FIC_IDX_GYR: rd_byte = rotation_rate_div10_q;
      `FIC_IDX_STAT: rd_byte = status_d;
      default: rd_byte = 8'h00;
    endcase
    rd_d = {24'h000000, rd_byte};
    err_d = !addr_ok || !(is_cfg(idx) || (!pwrite && idx == `FIC_IDX_STAT));
  end

  // apb handshake: one wait-free access cycle after setup
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= err_d;
      prdata <= (pwrite || err_d) ? 32'h00000000 : rd_d;
    end else if (commit) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // configuration storage, held until written again or reset
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      orientation_rate_divisor_q <= `FIC_RST_QDIV; // see R7
      event_interrupt_enable_q <= `FIC_RST_EVEN;
      fusion_option_control_q <= `FIC_RST_ALGO; // see R14
      compass_rate_q <= `FIC_RST_RATE;
      accel_rate_div10_q <= `FIC_RST_RATE;
      rotation_rate_div10_q <= `FIC_RST_RATE;
    end else if (do_wr) begin // see R22
      orientation_rate_divisor_q <= lane_pick(`FIC_IDX_QDIV, orientation_rate_divisor_q,
        lane_idx0, lane_idx1, lane_idx2, lane_idx3, pstrb, pwdata); // see R18
      event_interrupt_enable_q <= `FIC_EVEN_MASK & lane_pick(`FIC_IDX_EVEN,
        event_interrupt_enable_q, lane_idx0, lane_idx1, lane_idx2, lane_idx3,
        pstrb, pwdata); // see R16
      fusion_option_control_q <= `FIC_ALGO_MASK & lane_pick(`FIC_IDX_ALGO,
        fusion_option_control_q, lane_idx0, lane_idx1, lane_idx2, lane_idx3,
        pstrb, pwdata);
      compass_rate_q <= lane_pick(`FIC_IDX_MAG, compass_rate_q,
        lane_idx0, lane_idx1, lane_idx2, lane_idx3, pstrb, pwdata); // see R18
      accel_rate_div10_q <= lane_pick(`FIC_IDX_ACC, accel_rate_div10_q,
        lane_idx0, lane_idx1, lane_idx2, lane_idx3, pstrb, pwdata); // see R18
      rotation_rate_div10_q <= lane_pick(`FIC_IDX_GYR, rotation_rate_div10_q,
        lane_idx0, lane_idx1, lane_idx2, lane_idx3, pstrb, pwdata); // see R18
    end
  end

  // orientation tick every divisor-th gyro sample, zero treated as one
  wire [7:0] div_eff = (orientation_rate_divisor_q == 8'h00) ? 8'h01 :
                       orientation_rate_divisor_q; // see R7
  wire div_wrap = div_cnt_q >= div_eff - 8'h01;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_q <= 8'h00;
      orientation_tick <= 1'b0;
    end else begin
      orientation_tick <= 1'b0;
      if (!gyr_on) begin
        div_cnt_q <= 8'h00;
      end else if (rotation_sample) begin
        if (div_wrap) begin
          div_cnt_q <= 8'h00;
          orientation_tick <= 1'b1; // see R6
        end else begin
          div_cnt_q <= div_cnt_q + 8'h01;
        end
      end
    end
  end

  // event gating; restart bypasses its enable
  wire [5:0] ev_gate = event_pulse & event_interrupt_enable_q[5:0]; // see R16
  wire irq_d = event_pulse[`FIC_EV_RESTART] || (|ev_gate); // see R17

  // steering outputs, all registered
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      host_irq <= 1'b0;
      compass_rate_hz <= {`FIC_RATE_W{1'b0}};
      accel_rate_hz <= {`FIC_RATE_W{1'b0}};
      rotation_rate_hz <= {`FIC_RATE_W{1'b0}};
      sensor_on <= 3'b000;
      calib_on <= 3'b000;
      standby_allow <= 1'b0;
      unscaled_output_select <= 1'b0;
      euler_output_select <= 1'b0;
      six_dof_select <= 1'b0;
      enu_axes_select <= 1'b0;
      gyro_still_off_allow <= 1'b0;
      flags_out <= 3'b000;
      flags_valid <= 1'b0;
    end else begin
      host_irq <= irq_d;
      compass_rate_hz <= mag_req_hz; // see R1
      accel_rate_hz <= acc_use_hz; // see R5
      rotation_rate_hz <= gyr_use_hz; // see R5
      sensor_on <= {gyr_on, acc_on, mag_on}; // see R4
      // background calibration needs its sensor running
      calib_on <= {gyr_on, acc_on, mag_on}; // see R4
      standby_allow <= fusion_option_control_q[`FIC_ALGO_STANDBY]; // see R8
      unscaled_output_select <= fusion_option_control_q[`FIC_ALGO_RAW]; // see R9
      euler_output_select <= fusion_option_control_q[`FIC_ALGO_EULER]; // see R10
      six_dof_select <= fusion_option_control_q[`FIC_ALGO_6DOF]; // see R11
      enu_axes_select <= fusion_option_control_q[`FIC_ALGO_ENU]; // see R12
      gyro_still_off_allow <= fusion_option_control_q[`FIC_ALGO_GYRO_OFF]; // see R13
      // masked to zero rather than passing stale garbage
      flags_out <= all_on ? flags_in : 3'b000; // see R20
      flags_valid <= all_on; // see R20
    end
  end
endmodule // fic_regs

// ---- fic_sens_model.sv ----
// sensor side model: gyro sample pulses and algorithm status flags
module fic_sens_model (
  input wire core_clk,
  input wire nrst,
  input wire run,
  output logic rotation_sample,
  output logic [2:0] flags_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_q;
  // flags move every cycle so a stale copy cannot pass
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 2'h0;
      flags_in <= 3'h0;
    end else begin
      ph_q <= run ? ph_q + 2'h1 : 2'h0;
      flags_in <= flags_in + 3'h3;
    end
  end
  // one sample every four cycles while run is held
  assign rotation_sample = run && (ph_q == 2'h3);
endmodule // fic_sens_model

// ---- fic_regs_checker.sv ----
// assertions on the configuration register bank ports
`include "fic_defs.vh"
module fic_regs_checker (
  input wire core_clk,
  input wire nrst,
  input wire [5:0] event_pulse,
  input wire rotation_sample,
  input wire host_irq,
  input wire orientation_tick,
  input wire [`FIC_RATE_W-1:0] compass_rate_hz,
  input wire [`FIC_RATE_W-1:0] accel_rate_hz,
  input wire [`FIC_RATE_W-1:0] rotation_rate_hz,
  input wire [2:0] sensor_on,
  input wire [2:0] calib_on,
  input wire [2:0] flags_out,
  input wire flags_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  chk_restart_irq: assert property (event_pulse[0] |=> host_irq)
    else $error("restart event gave no interrupt");
  chk_irq_cause: assert property (host_irq |-> $past(event_pulse) != 6'h00)
    else $error("interrupt without event");
  chk_compass_on: assert property (sensor_on[0] == (compass_rate_hz != 12'h000))
    else $error("compass run state wrong");
  chk_accel_on: assert property (sensor_on[1] == (accel_rate_hz != 12'h000))
    else $error("accel run state wrong");
  chk_rot_on: assert property (sensor_on[2] == (rotation_rate_hz != 12'h000))
    else $error("gyro run state wrong");
  chk_calib_follow: assert property (calib_on == sensor_on)
    else $error("calibration not tied to sensor");
  chk_flags_mask: assert property (!flags_valid |-> flags_out == 3'h0)
    else $error("flags leak while a rate is zero");
  chk_valid_all: assert property (flags_valid == (&sensor_on))
    else $error("flag valid wrong");
  chk_tick_cause: assert property (orientation_tick |-> $past(rotation_sample))
    else $error("orientation tick without sample");
  cover property (host_irq);
  cover property (orientation_tick);
  cover property ($fell(flags_valid));
endmodule // fic_regs_checker
bind fic_regs fic_regs_checker u_chk (.core_clk, .nrst, .event_pulse, .rotation_sample,
  .host_irq, .orientation_tick, .compass_rate_hz, .accel_rate_hz, .rotation_rate_hz,
  .sensor_on, .calib_on, .flags_out, .flags_valid);

// ---- fic_regs_tb.sv ----
// self-checking bench for the configuration register bank
module fic_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, nrst, psel, penable, pwrite, run, rotation_sample;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic [5:0] event_pulse;
  logic [2:0] flags_in, sensor_on, calib_on, flags_out;
  logic pready, pslverr, host_irq, orientation_tick, flags_valid;
  logic [11:0] compass_rate_hz, accel_rate_hz, rotation_rate_hz;
  logic standby_allow, unscaled_output_select, euler_output_select;
  logic six_dof_select, enu_axes_select, gyro_still_off_allow;
  logic [32:0] exp_q[$];
  logic [31:0] adr[6] = '{32'hc8, 32'hcc, 32'h150, 32'h154, 32'h158, 32'h15c};
  logic [7:0] rv[6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  int err_total = 0, checked = 0, ticks = 0, irqs = 0, seed, i;
  logic [31:0] v;
  fic_regs DUT (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .event_pulse, .rotation_sample, .flags_in, .host_irq,
    .orientation_tick, .compass_rate_hz, .accel_rate_hz, .rotation_rate_hz, .sensor_on,
    .calib_on, .standby_allow, .unscaled_output_select, .euler_output_select,
    .six_dof_select, .enu_axes_select, .gyro_still_off_allow, .flags_out, .flags_valid);
  fic_sens_model u_sens (.core_clk, .nrst, .run, .rotation_sample, .flags_in);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task end_sim;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic [32:0] e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    if (!w) exp_q.push_back(e);
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_total++;
      end_sim();
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s, 33'h0);
  endtask
  task rd(input logic [31:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, 4'h0, e);
  endtask
  task ev(input int b, input int e);
    irqs = 0;
    @(posedge core_clk);
    event_pulse <= 6'h01 << b;
    @(posedge core_clk);
    event_pulse <= 6'h00;
    repeat (3) @(posedge core_clk);
    chk(irqs, e);
  endtask
  task burst(input int n, input int e);
    ticks = 0;
    run <= 1'b1;
    repeat (4 * n) @(posedge core_clk);
    run <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(ticks, e);
  endtask
  // read results are compared in bus order as they appear
  always @(posedge core_clk) begin
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : 33'hx);
    if (orientation_tick === 1'b1) ticks++;
    if (host_irq === 1'b1) irqs++;
  end
  initial begin
    {nrst, psel, penable, pwrite, run, paddr, pwdata, pstrb, event_pulse} = '0;
    seed = 71;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    for (i = 0; i < 6; i++) rd(adr[i], {25'h0, rv[i]});
    $display("reset values done");
    wr(32'h154, 32'h000f0a64, 4'h7);
    rd(32'h154, 33'h64);
    rd(32'h158, 33'h0a);
    rd(32'h15c, 33'h0f);
    chk(compass_rate_hz, 33'd100);
    chk(accel_rate_hz, 33'd100);
    chk(rotation_rate_hz, 33'd200);
    chk(sensor_on, 33'h7);
    // flags pass with one clock of lag once every rate is nonzero
    @(negedge core_clk);
    v = flags_in;
    @(negedge core_clk);
    chk({flags_valid, flags_out}, {29'h0, 1'b1, v[2:0]});
    rd(32'h40, 33'h100000000);
    $display("rates done");
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hff : $random(seed);
      wr(32'h150, v, 4'h1);
      rd(32'h150, {25'h0, v[7:0] & 8'h6f});
      chk({gyro_still_off_allow, enu_axes_select, 1'b0, six_dof_select, euler_output_select,
           unscaled_output_select, standby_allow}, v[6:0] & 7'h6f);
    end
    $display("control done");
    wr(32'h0c8, 32'h3, 4'h1);
    burst(6, 2);
    wr(32'h0c8, 32'h0, 4'h1);
    burst(3, 3);
    $display("divisor done");
    wr(32'h0cc, 32'h0, 4'h1);
    ev(0, 1);
    for (i = 1; i < 6; i++) ev(i, 0);
    wr(32'h0cc, 32'h3f, 4'h1);
    for (i = 0; i < 6; i++) ev(i, 1);
    $display("events done");
    wr(32'h158, 32'h0, 4'h1);
    // register lands at the commit edge, outputs one clock later
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({calib_on, sensor_on}, 33'h2d);
    chk({flags_valid, accel_rate_hz}, 33'h0);
    rd(32'h15c, 33'h0f);
    wr(32'h154, 32'h0, 4'h1);
    wr(32'h150, 32'h08, 4'h1);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({six_dof_select, sensor_on}, 33'hc);
    $display("zero rate done");
    end_sim();
  end
endmodule // fic_regs_tb
